//--- ext_irq_defines.svh
// Constants of the external interrupt edge detector: register indices,
// field positions, reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_EDGE_SELECT      16'hfff2
`define IDX_INT_ENABLE       16'hfff3
`define IDX_INT_FLAG         16'hfff6
`define IDX_PIN_FUNCTION     16'hf085
`define IDX_PORT_MODE_B      16'hf0c0
`define IDX_EVENT_EDGE       16'hf0c1
`define IDX_COND_CODE        16'hf0c2

// ==========================================================
// Field positions
`define EDGE_BIT_A           0
`define EDGE_BIT_B           1
`define EDGE_BIT_TRIG        2
`define EDGE_BIT_NMI         3
`define EN_BIT_A             0
`define EN_BIT_B             1
`define EN_BIT_EVC           2
`define EN_BIT_RTC           3
`define FLAG_BIT_A           0
`define FLAG_BIT_B           1
`define FLAG_BIT_EVC         2
`define PFC_A_LSB            0
`define PFC_B_LSB            2
`define PFC_SERIAL_LSB       4
`define PMB_BIT_A            0
`define PMB_BIT_B            1
`define COND_BIT_IMASK       7

// ==========================================================
// Reset values, and the prohibited source code
`define RST_EDGE_SELECT      4'h0
`define RST_INT_ENABLE       4'h0
`define RST_INT_FLAG         3'h0
`define RST_PIN_FUNCTION     8'h00
`define RST_PORT_MODE_B      2'h3
`define RST_EVENT_EDGE       8'h00
`define RST_IMASK            1'b1
`define SRC_PROHIBITED       2'h3

`endif

//--- ext_irq_pkg.sv
// Types shared by the external interrupt edge detector.
// Assumes ext_irq_defines.svh is on the include path.
`default_nettype none
package ext_irq_pkg;
  `include "ext_irq_defines.svh"

  // State of one line detector
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] last_src;
    logic       last_assigned;
    logic       prev;
    logic       prev_valid;
    logic       edge_seen;
  } line_state_t;

  // State of the register block
  typedef struct packed {
    logic [3:0]  edge_select;
    logic [3:0]  enables;
    logic [2:0]  flags;
    logic [7:0]  pin_func;
    logic [1:0]  port_mode;
    logic [7:0]  event_edge;
    logic        imask;
    logic        clr_blocked;
    logic [31:0] rdata;
    logic        slverr;
  } regs_t;
endpackage : ext_irq_pkg
`default_nettype wire

//--- edge_line_if.sv
// Link between the register block and one line detector.
// Assumes both ends run on the same clock.
`default_nettype none
interface edge_line_if;
  logic [1:0] src_sel;
  logic       assigned;
  logic       rising;
  logic       edge_pulse;

  modport ctrl (output src_sel, output assigned, output rising, input edge_pulse);
  modport det  (input src_sel, input assigned, input rising, output edge_pulse);
endinterface : edge_line_if
`default_nettype wire

//--- edge_detect_line.sv
// One external interrupt line: pin synchroniser, source mux, edge detect.
// Assumes pins are asynchronous and active low; selection from pclk logic.
`default_nettype none
module edge_detect_line
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Candidate pins, active low
  input  wire logic [2:0] pins_n,
  // Control link
  edge_line_if.det   lif
);

  line_state_t state_reg;
  line_state_t state_next;
  logic        cur;

  // ==========================================================
  // Next state
  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = pins_n;
    state_next.sync2 = state_reg.sync1;
    case (lif.src_sel)
      2'h0:    cur = state_reg.sync2[0];
      2'h1:    cur = state_reg.sync2[1];
      2'h2:    cur = state_reg.sync2[2];
      default: cur = 1'b1;
    endcase
    state_next.prev          = cur;
    state_next.last_src      = lif.src_sel;
    state_next.last_assigned = lif.assigned;
    // New source needs one sample before edges count
    state_next.prev_valid    = lif.assigned && (lif.src_sel == state_reg.last_src)
                               && state_reg.last_assigned;
    // 1 rising, 0 falling; compare with last sample
    state_next.edge_seen = state_reg.prev_valid && lif.assigned &&
                           (lif.rising ? (cur && !state_reg.prev)
                                       : (!cur && state_reg.prev));
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{sync1: 3'h7, sync2: 3'h7, last_src: 2'h0, last_assigned: 1'b0,
                     prev: 1'b1, prev_valid: 1'b0, edge_seen: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign lif.edge_pulse = state_reg.edge_seen;

endmodule : edge_detect_line
`default_nettype wire

//--- external_irq_edge_detect.sv
// External interrupt edge detector with APB register access.
// Assumes pins are asynchronous and active low; the event counter request
// and the APB master run on pclk.
//
// How it works
// - Two line requests come from active-low pins: dedicated ones, or for line b the serial input or timer clock pin.
// - One edge select bit per line picks rising or falling edge.
// - Selected edge on an assigned pin sets the flag and requests.
// - Enable bit at 0 blocks that line's request.
// - Condition-code mask bit at 1 holds irq_out low; the line request outputs stay set.
// - Edge select register also holds NMI and converter trigger edges.
// - Enable register holds clock, event counter and both line enables.
// - Flag register holds event counter and both line flags.
// - Pin function register picks line sources and serial unit functions.
// - Switching a line's pin function sets its flag without an edge.
// - Flag clear right after a pin function write is ignored.
// - Edge select 0 means falling, 1 means rising.
// - Flags clear only by writing 0; writing 1 does nothing.
// - Line b source 00 first pin, 01 serial input, 10 timer clock.
//
// The implementer's own choices: the APB slave port and the register offsets.
`default_nettype none
module external_irq_edge_detect
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,

  // APB slave
  input  wire logic [17:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,

  // Line a candidate pins, active low
  input  wire logic        line_a_source_pin0_n,
  input  wire logic        line_a_source_pin1_n,
  input  wire logic        line_a_source_pin2_n,

  // Line b candidate pins, active low
  input  wire logic        line_b_source_pin0_n,
  input  wire logic        serial_input_pin_n,
  input  wire logic        timer_clock_pin_n,

  // Event counter request, one-cycle pulse on pclk
  input  wire logic        event_counter_pulse,

  // Requests toward the CPU
  output logic             ext_irq_line_a_req,
  output logic             ext_irq_line_b_req,
  output logic             event_counter_interrupt_req,
  output logic             irq_out,

  // Settings used by neighbouring blocks
  output logic             nmi_edge_rising,
  output logic             converter_trigger_edge_rising,
  output logic             rtc_irq_enable,
  output logic       [3:0] sync_serial_unit_func,
  output logic       [7:0] event_edge_select
);

  // ==========================================================
  // Helpers
  // Register index to APB byte address
  function automatic logic [17:0] byte_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

  // Line is tied to a pin when its port mode allows and the code is legal
  function automatic logic line_assigned(input logic mode, input logic [1:0] src);
    return mode && (src != `SRC_PROHIBITED);
  endfunction : line_assigned

  // a line's pin moves when its assignment or source changes
  function automatic logic source_switched(input logic       asg_old,
                                           input logic       asg_new,
                                           input logic [1:0] src_old,
                                           input logic [1:0] src_new);
    return (asg_new != asg_old) || (asg_new && (src_new != src_old));
  endfunction : source_switched

  // ==========================================================
  // Declarations
  regs_t       regs_reg;
  regs_t       regs_next;
  edge_line_if line_a_if ();
  edge_line_if line_b_if ();

  // Bus phase
  logic        setup_phase;
  logic        wr_done;
  logic        any_done;

  // Register hits
  logic        hit_edge;
  logic        hit_enable;
  logic        hit_flag;
  logic        hit_pfc;
  logic        hit_pmb;
  logic        hit_evedge;
  logic        hit_cond;
  logic        hit_any;

  // Line assignment, now and after a write
  logic [1:0]  src_a_now;
  logic [1:0]  src_b_now;
  logic [1:0]  src_a_new;
  logic [1:0]  src_b_new;
  logic        asg_a_now;
  logic        asg_b_now;
  logic        asg_a_new;
  logic        asg_b_new;

  // Flag and read paths
  logic [2:0]  set_events;
  logic [2:0]  flag_keep;
  logic [7:0]  pfc_wr;
  logic [1:0]  pmb_wr;
  logic [31:0] read_mux;

  // ==========================================================
  // Address decode
  always_comb begin
    hit_edge   = 1'b0;
    hit_enable = 1'b0;
    hit_flag   = 1'b0;
    hit_pfc    = 1'b0;
    hit_pmb    = 1'b0;
    hit_evedge = 1'b0;
    hit_cond   = 1'b0;
    // Full compare, so aliases of a register are refused
    if (paddr == byte_addr(`IDX_EDGE_SELECT)) begin
      hit_edge = 1'b1;
    end else if (paddr == byte_addr(`IDX_INT_ENABLE)) begin
      hit_enable = 1'b1;
    end else if (paddr == byte_addr(`IDX_INT_FLAG)) begin
      hit_flag = 1'b1;
    end else if (paddr == byte_addr(`IDX_PIN_FUNCTION)) begin
      hit_pfc = 1'b1;
    end else if (paddr == byte_addr(`IDX_PORT_MODE_B)) begin
      hit_pmb = 1'b1;
    end else if (paddr == byte_addr(`IDX_EVENT_EDGE)) begin
      hit_evedge = 1'b1;
    end else if (paddr == byte_addr(`IDX_COND_CODE)) begin
      hit_cond = 1'b1;
    end
    hit_any = hit_edge | hit_enable | hit_flag | hit_pfc | hit_pmb | hit_evedge | hit_cond;
  end

  // ==========================================================
  // Read data, taken in the setup cycle so prdata is a flop
  // No cost, since the slave never waits
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_edge) begin
      read_mux[3:0] = regs_reg.edge_select;
    end else if (hit_enable) begin
      read_mux[3:0] = regs_reg.enables;
    end else if (hit_flag) begin
      read_mux[2:0] = regs_reg.flags;
    end else if (hit_pfc) begin
      read_mux[7:0] = regs_reg.pin_func;
    end else if (hit_pmb) begin
      read_mux[1:0] = regs_reg.port_mode;
    end else if (hit_evedge) begin
      read_mux[7:0] = regs_reg.event_edge;
    end else if (hit_cond) begin
      read_mux[`COND_BIT_IMASK] = regs_reg.imask;
    end
  end

  // ==========================================================
  // Pin assignment, present and after a write in progress
  always_comb begin
    pfc_wr    = hit_pfc ? pwdata[7:0] : regs_reg.pin_func;
    pmb_wr    = hit_pmb ? pwdata[1:0] : regs_reg.port_mode;

    // Sources and assignments, now and after the write
    src_a_now = regs_reg.pin_func[`PFC_A_LSB +: 2];
    src_b_now = regs_reg.pin_func[`PFC_B_LSB +: 2];
    src_a_new = pfc_wr[`PFC_A_LSB +: 2];
    src_b_new = pfc_wr[`PFC_B_LSB +: 2];

    asg_a_now = line_assigned(regs_reg.port_mode[`PMB_BIT_A], src_a_now);
    asg_b_now = line_assigned(regs_reg.port_mode[`PMB_BIT_B], src_b_now);
    asg_a_new = line_assigned(pmb_wr[`PMB_BIT_A], src_a_new);
    asg_b_new = line_assigned(pmb_wr[`PMB_BIT_B], src_b_new);
  end

  // ==========================================================
  // Register next state
  always_comb begin
    regs_next   = regs_reg;
    setup_phase = psel && !penable;
    any_done    = psel && penable;
    // Unmapped writes are dropped; pslverr reports them
    wr_done     = any_done && pwrite && hit_any;

    if (setup_phase) begin
      regs_next.rdata  = read_mux;
      regs_next.slverr = !hit_any;
    end

    if (wr_done) begin
      // edge selections, also NMI and trigger pins
      if (hit_edge) begin
        regs_next.edge_select = pwdata[3:0];
      end

      // enables incl. clock and event counter
      if (hit_enable) begin
        regs_next.enables = pwdata[3:0];
      end

      // line sources and serial unit functions
      if (hit_pfc) begin
        regs_next.pin_func = pwdata[7:0];
      end

      // Port mode and event edge are plain stores
      if (hit_pmb) begin
        regs_next.port_mode = pwdata[1:0];
      end
      if (hit_evedge) begin
        regs_next.event_edge = pwdata[7:0];
      end

      if (hit_cond) begin
        regs_next.imask = pwdata[`COND_BIT_IMASK];
      end
    end

    // clear right after a function write is swallowed
    if (any_done) begin
      regs_next.clr_blocked = wr_done && (hit_pfc || hit_pmb || hit_evedge);
    end

    // write 0 clears, write 1 keeps
    flag_keep = regs_reg.flags;
    if (wr_done && hit_flag && !regs_reg.clr_blocked) begin
      flag_keep = regs_reg.flags & pwdata[2:0];
    end

    set_events                = 3'h0;
    set_events[`FLAG_BIT_A]   = line_a_if.edge_pulse;
    set_events[`FLAG_BIT_B]   = line_b_if.edge_pulse;
    set_events[`FLAG_BIT_EVC] = event_counter_pulse;

    // switching a line's function raises a spurious flag
    if (wr_done && (hit_pfc || hit_pmb)) begin
      if (source_switched(asg_a_now, asg_a_new, src_a_now, src_a_new)) begin
        set_events[`FLAG_BIT_A] = 1'b1;
      end
      if (source_switched(asg_b_now, asg_b_new, src_b_now, src_b_new)) begin
        set_events[`FLAG_BIT_B] = 1'b1;
      end
    end

    // Set wins over a clear in the same cycle
    regs_next.flags = flag_keep | set_events;
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Mask starts set, so nothing reaches the CPU before software asks
      regs_reg <= '{edge_select: `RST_EDGE_SELECT,
                    enables:     `RST_INT_ENABLE,
                    flags:       `RST_INT_FLAG,
                    pin_func:    `RST_PIN_FUNCTION,
                    port_mode:   `RST_PORT_MODE_B,
                    event_edge:  `RST_EVENT_EDGE,
                    imask:       `RST_IMASK,
                    clr_blocked: 1'b0,
                    rdata:       32'h0000_0000,
                    slverr:      1'b0};
    end else begin
      regs_reg <= regs_next;
    end
  end

  // ==========================================================
  // Line detectors
  // each line watches its chosen active-low pin
  assign line_a_if.src_sel  = src_a_now;
  assign line_a_if.assigned = asg_a_now;
  assign line_a_if.rising   = regs_reg.edge_select[`EDGE_BIT_A];
  assign line_b_if.src_sel  = src_b_now;
  assign line_b_if.assigned = asg_b_now;
  assign line_b_if.rising   = regs_reg.edge_select[`EDGE_BIT_B];

  // Line a: three alternative pins
  edge_detect_line line_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pins_n  ({line_a_source_pin2_n, line_a_source_pin1_n, line_a_source_pin0_n}),
    .lif     (line_a_if)
  );

  // Line b: first pin, serial input, timer clock
  edge_detect_line line_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pins_n  ({timer_clock_pin_n, serial_input_pin_n, line_b_source_pin0_n}),
    .lif     (line_b_if)
  );

  // ==========================================================
  // Outputs
  // Zero-wait slave; data was captured during setup
  assign pready  = 1'b1;
  assign prdata  = regs_reg.rdata;
  assign pslverr = regs_reg.slverr;

  // request only with flag and enable set
  assign ext_irq_line_a_req = regs_reg.flags[`FLAG_BIT_A] &&
                              regs_reg.enables[`EN_BIT_A];
  assign ext_irq_line_b_req = regs_reg.flags[`FLAG_BIT_B] &&
                              regs_reg.enables[`EN_BIT_B];
  assign event_counter_interrupt_req = regs_reg.flags[`FLAG_BIT_EVC] &&
                                       regs_reg.enables[`EN_BIT_EVC];
  // condition-code mask blocks all maskable requests
  assign irq_out = !regs_reg.imask && (ext_irq_line_a_req || ext_irq_line_b_req ||
                                       event_counter_interrupt_req);

  assign nmi_edge_rising               = regs_reg.edge_select[`EDGE_BIT_NMI];
  assign converter_trigger_edge_rising = regs_reg.edge_select[`EDGE_BIT_TRIG];
  assign rtc_irq_enable                = regs_reg.enables[`EN_BIT_RTC];
  assign sync_serial_unit_func         = regs_reg.pin_func[`PFC_SERIAL_LSB +: 4];
  assign event_edge_select             = regs_reg.event_edge;

endmodule : external_irq_edge_detect
`default_nettype wire

//--- ext_irq_props.sv
// Checker on the detector ports; mirrors written settings from APB.
// Assumes registers change only through APB writes.
`default_nettype none
`include "ext_irq_defines.svh"
module ext_irq_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [17:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Pins and requests
  input wire logic        line_a_source_pin0_n,
  input wire logic        line_b_source_pin0_n,
  input wire logic        event_counter_pulse,
  input wire logic        ext_irq_line_a_req,
  input wire logic        ext_irq_line_b_req,
  input wire logic        event_counter_interrupt_req,
  input wire logic        irq_out,
  // Settings
  input wire logic        nmi_edge_rising,
  input wire logic        converter_trigger_edge_rising,
  input wire logic        rtc_irq_enable,
  input wire logic [3:0]  sync_serial_unit_func,
  input wire logic [7:0]  event_edge_select
);
  // ====
  // Mirror of written settings
  logic [3:0] es, en;
  logic [7:0] pf, ee;
  logic [1:0] pm;
  logic       im;
  wire        wr = psel && penable && pready && pwrite;
  wire [15:0] idx = paddr[17:2];
  wire        clr_a = wr && (idx == `IDX_INT_FLAG && !pwdata[0] || idx == `IDX_INT_ENABLE);
  wire        any_req = ext_irq_line_a_req || ext_irq_line_b_req
                        || event_counter_interrupt_req;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      es <= `RST_EDGE_SELECT;
      en <= `RST_INT_ENABLE;
      pf <= `RST_PIN_FUNCTION;
      pm <= `RST_PORT_MODE_B;
      ee <= `RST_EVENT_EDGE;
      im <= `RST_IMASK;
    end else if (wr) begin
      case (idx)
        `IDX_EDGE_SELECT:  es <= pwdata[3:0];
        `IDX_INT_ENABLE:   en <= pwdata[3:0];
        `IDX_PIN_FUNCTION: pf <= pwdata[7:0];
        `IDX_PORT_MODE_B:  pm <= pwdata[1:0];
        `IDX_EVENT_EDGE:   ee <= pwdata[7:0];
        `IDX_COND_CODE:    im <= pwdata[7];
        default: ;
      endcase
    end
  end
  // ====
  // Properties
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_switch;
    wr && (idx == `IDX_PIN_FUNCTION || idx == `IDX_PORT_MODE_B || idx == `IDX_EVENT_EDGE);
  endsequence
  sequence s_quick_clr;
    wr && idx == `IDX_INT_FLAG && !pwdata[1] && ext_irq_line_b_req;
  endsequence
  a_irq_level: assert property (
    irq_out == (!im && any_req)) else $error("irq_out disagrees with mask and requests");
  a_req_needs_en: assert property (
    !(ext_irq_line_a_req && !en[0]) && !(ext_irq_line_b_req && !en[1]))
    else $error("line request without enable");
  a_fall_sets_a: assert property (
    $fell(line_a_source_pin0_n) && pm[0] && pf[1:0] == 2'h0 && !es[0] && en[0]
    |-> ##[1:5] ext_irq_line_a_req) else $error("falling edge on line a not flagged");
  a_rise_sets_b: assert property (
    $rose(line_b_source_pin0_n) && pm[1] && pf[3:2] == 2'h0 && es[1] && en[1]
    |-> ##[1:5] ext_irq_line_b_req) else $error("rising edge on line b not flagged");
  a_clear_by_write: assert property (
    $fell(ext_irq_line_a_req) |-> $past(clr_a)) else $error("line a request dropped alone");
  a_event_sets: assert property (
    event_counter_pulse && en[2] |=> event_counter_interrupt_req)
    else $error("event counter pulse not flagged");
  a_settings_mirror: assert property (
    {nmi_edge_rising, converter_trigger_edge_rising, rtc_irq_enable} == {es[3], es[2], en[3]}
    && sync_serial_unit_func == pf[7:4] && event_edge_select == ee)
    else $error("setting outputs differ from written values");
  a_switch_flags_b: assert property (
    wr && idx == `IDX_PIN_FUNCTION && pwdata[3:2] != pf[3:2] && pm[1] && en[1]
    |=> ext_irq_line_b_req) else $error("source switch did not flag line b");
  a_blocked_clear: assert property (
    s_switch ##3 s_quick_clr |=> ext_irq_line_b_req) else $error("quick clear took effect");
endmodule : ext_irq_props
bind external_irq_edge_detect ext_irq_props u_props (.*);
`default_nettype wire

//--- switch_cpu_model.sv
// Far side: switches on the six candidate pins, a CPU counting interrupts.
// Assumes press levels change just after a rising edge.
`default_nettype none
module switch_cpu_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Switches, 1 = pressed; pins active low
  input  wire logic [5:0] press,
  output logic      [5:0] pins_n,
  // CPU side
  input  wire logic       irq_out,
  output logic      [7:0] irq_taken
);
  logic irq_last;
  // ====
  // pins held high idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_n    <= 6'h3f;
      irq_last  <= 1'b0;
      irq_taken <= 8'h00;
    end else begin
      pins_n    <= ~press;
      irq_last  <= irq_out;
      irq_taken <= irq_taken + {7'h00, irq_out && !irq_last};
    end
  end
endmodule : switch_cpu_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the external interrupt edge detector.
// Assumes the far side model and the checker bind are compiled first.
`default_nettype none
`include "ext_irq_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Signals
  logic        pclk, err;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic        event_counter_pulse = 1'b0;
  logic [5:0]  press = 6'h00;
  logic [31:0] rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_irq_line_a_req, ext_irq_line_b_req, irq_out;
  wire         event_counter_interrupt_req, nmi_edge_rising, converter_trigger_edge_rising;
  wire         rtc_irq_enable;
  wire  [3:0]  sync_serial_unit_func;
  wire  [7:0]  event_edge_select, taken;
  wire  [5:0]  pins_n;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  external_irq_edge_detect uut (
    .*,
    .line_a_source_pin0_n(pins_n[0]),
    .line_a_source_pin1_n(pins_n[1]),
    .line_a_source_pin2_n(pins_n[2]),
    .line_b_source_pin0_n(pins_n[3]),
    .serial_input_pin_n  (pins_n[4]),
    .timer_clock_pin_n   (pins_n[5])
  );
  switch_cpu_model far (.*, .irq_taken(taken));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard, far above the expected run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // ====
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends once pready is high; the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic sw(input logic [15:0] idx, input logic [31:0] d);
    apb(idx, 1'b1, d);
    apb(`IDX_INT_FLAG, 1'b0, 32'h0);
    apb(`IDX_INT_FLAG, 1'b1, 32'h0);
  endtask : sw
  task automatic pin(input int b, input logic v);
    press[b] <= v;
    repeat (8) @(posedge pclk);
  endtask : pin
  // ====
  // Scenarios
  task automatic t_reset;
    rdc(`IDX_EDGE_SELECT, 32'h0);
    rdc(`IDX_INT_ENABLE, 32'h0);
    rdc(`IDX_INT_FLAG, 32'h0);
    rdc(`IDX_PIN_FUNCTION, 32'h0);
    rdc(`IDX_PORT_MODE_B, 32'h3);
    rdc(`IDX_COND_CODE, 32'h80);
    apb(16'h0123, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_edge_a;
    apb(`IDX_INT_ENABLE, 1'b1, 32'h1);
    pin(0, 1'b1);
    rdc(`IDX_INT_FLAG, 32'h1);
    chk(ext_irq_line_a_req, 1'b1);
    chk(irq_out, 1'b0);
    apb(`IDX_COND_CODE, 1'b1, 32'h0);
    chk(irq_out, 1'b1);
    @(posedge pclk);
    chk(taken, 8'h1);
    apb(`IDX_COND_CODE, 1'b1, 32'h80);
    chk(irq_out, 1'b0);
    pin(0, 1'b0);
    apb(`IDX_INT_FLAG, 1'b1, 32'h1);
    rdc(`IDX_INT_FLAG, 32'h1);
    apb(`IDX_INT_FLAG, 1'b1, 32'h0);
    rdc(`IDX_INT_FLAG, 32'h0);
    apb(`IDX_INT_ENABLE, 1'b1, 32'h0);
    pin(0, 1'b1);
    chk(ext_irq_line_a_req, 1'b0);
    rdc(`IDX_INT_FLAG, 32'h1);
    pin(0, 1'b0);
    apb(`IDX_INT_FLAG, 1'b1, 32'h0);
    $display("test edge a done");
  endtask : t_edge_a
  task automatic t_rise_b;
    apb(`IDX_EDGE_SELECT, 1'b1, 32'h2);
    apb(`IDX_INT_ENABLE, 1'b1, 32'h2);
    pin(3, 1'b1);
    rdc(`IDX_INT_FLAG, 32'h0);
    pin(3, 1'b0);
    rdc(`IDX_INT_FLAG, 32'h2);
    chk(ext_irq_line_b_req, 1'b1);
    apb(`IDX_INT_FLAG, 1'b1, 32'h0);
    rdc(`IDX_INT_FLAG, 32'h0);
    $display("test rise b done");
  endtask : t_rise_b
  task automatic t_source;
    int s;
    apb(`IDX_COND_CODE, 1'b1, 32'h80);
    for (int i = 1; i < 4; i++) begin
      s = i % 3;
      apb(`IDX_PIN_FUNCTION, 1'b1, (s << 2) | s);
      apb(`IDX_INT_FLAG, 1'b1, 32'h0);
      rdc(`IDX_INT_FLAG, 32'h3);
      apb(`IDX_INT_FLAG, 1'b1, 32'h0);
      rdc(`IDX_INT_FLAG, 32'h0);
      pin(3 + (s + 1) % 3, 1'b1);
      pin(3 + (s + 1) % 3, 1'b0);
      pin((s + 1) % 3, 1'b1);
      pin((s + 1) % 3, 1'b0);
      rdc(`IDX_INT_FLAG, 32'h0);
      pin(3 + s, 1'b1);
      pin(3 + s, 1'b0);
      pin(s, 1'b1);
      pin(s, 1'b0);
      rdc(`IDX_INT_FLAG, 32'h3);
      apb(`IDX_INT_FLAG, 1'b1, 32'h0);
    end
    sw(`IDX_PIN_FUNCTION, 32'hf);
    pin(3, 1'b1);
    pin(3, 1'b0);
    pin(0, 1'b1);
    pin(0, 1'b0);
    rdc(`IDX_INT_FLAG, 32'h0);
    sw(`IDX_PIN_FUNCTION, 32'h0);
    sw(`IDX_PORT_MODE_B, 32'h2);
    pin(0, 1'b1);
    pin(0, 1'b0);
    rdc(`IDX_INT_FLAG, 32'h0);
    sw(`IDX_PORT_MODE_B, 32'h3);
    $display("test source done");
  endtask : t_source
  task automatic t_misc;
    apb(`IDX_EDGE_SELECT, 1'b1, 32'hc);
    chk({nmi_edge_rising, converter_trigger_edge_rising}, 2'h3);
    apb(`IDX_INT_ENABLE, 1'b1, 32'hc);
    chk(rtc_irq_enable, 1'b1);
    apb(`IDX_PIN_FUNCTION, 1'b1, 32'ha0);
    chk(sync_serial_unit_func, 4'ha);
    apb(`IDX_EVENT_EDGE, 1'b1, 32'h5a);
    chk(event_edge_select, 8'h5a);
    event_counter_pulse <= 1'b1;
    @(posedge pclk);
    event_counter_pulse <= 1'b0;
    @(posedge pclk);
    chk(event_counter_interrupt_req, 1'b1);
    rdc(`IDX_INT_FLAG, 32'h4);
    apb(`IDX_INT_FLAG, 1'b1, 32'h0);
    rdc(`IDX_INT_FLAG, 32'h0);
    $display("test misc done");
  endtask : t_misc
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_edge_a();
    t_rise_b();
    t_source();
    t_misc();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
